// *** hw/didec_edge_detect.sv ***
`timescale 1ns/1ps
module didec_edge_detect
  import didec_pkg::*;
#(
  parameter int unsigned W = 4
) (
  input  wire logic         clk,
  input  wire logic         alarm_clear_input_n,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] rise
);

  logic [W-1:0] prevQ;

  always_ff @(posedge clk or negedge alarm_clear_input_n) begin
    if (!alarm_clear_input_n) begin
      prevQ <= '0;
    end else begin
      prevQ <= din;
    end
  end

  // Each bit is compared with its own value one clock earlier.
  for (genvar i = 0; i < W; i++) begin : g_bit
    assign rise[i] = din[i] & ~prevQ[i];
  end

endmodule : didec_edge_detect

// *** hw/didec_func_slot.sv ***
`timescale 1ns/1ps
module didec_func_slot
  import didec_pkg::*;
(
  input  wire logic [7:0] code,
  input  wire logic       level,
  input  wire logic       rise,
  input  wire logic       clearLevel,
  output didec_req_s      hits
);

  // Mode gating is applied once in the parent, after all slots merge.
  always_comb begin
    hits = '0;
    case (code)
      CODE_SERVO:   hits.servoOn    = level;
      CODE_ALARM:   hits.alarmClear = rise;
      CODE_GAIN:    hits.gainBoost  = level;
      CODE_PCLEAR:  hits.pulseClear = clearLevel ? level : rise;
      CODE_ZHOLD:   hits.zeroHold   = level;
      CODE_REVERSE: hits.cmdReverse = level;
      CODE_TRQCAP:  hits.torqueCap  = level;
      CODE_SPDCAP:  hits.speedCap   = level;
      default:      hits = '0;
    endcase
  end

endmodule : didec_func_slot

// *** hw/didec_pkg.sv ***
package didec_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Function codes that a digital input may be assigned.
  localparam logic [7:0] CODE_NONE     = 8'h00;
  localparam logic [7:0] CODE_SERVO    = 8'h01;
  localparam logic [7:0] CODE_ALARM    = 8'h02;
  localparam logic [7:0] CODE_GAIN     = 8'h03;
  localparam logic [7:0] CODE_PCLEAR   = 8'h04;
  localparam logic [7:0] CODE_ZHOLD    = 8'h05;
  localparam logic [7:0] CODE_REVERSE  = 8'h06;
  localparam logic [7:0] CODE_RESERVED = 8'h07;
  localparam logic [7:0] CODE_TRQCAP   = 8'h09;
  localparam logic [7:0] CODE_SPDCAP   = 8'h10;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets and reset values.
  localparam int unsigned   ADDR_W      = 4;
  localparam logic [3:0]    ADDR_CTRL   = 4'h0;
  localparam logic [3:0]    ADDR_THRESH = 4'h4;
  localparam logic [3:0]    ADDR_FUNC   = 4'h8;
  localparam logic [3:0]    ADDR_STATUS = 4'hC;
  localparam logic [31:0]   FUNC_RST    = 32'h0000_0000;
  localparam logic [15:0]   THRESH_RST  = 16'h000A;
  localparam logic [1:0]    GAIN_SEL_ON = 2'h1;

  // Control word width and input field position inside the status word.
  localparam int unsigned CTRL_W         = 7;
  localparam int unsigned STATUS_DIN_LSB = 8;

  typedef enum logic [1:0] {
    MODE_PT   = 2'b00,
    MODE_S    = 2'b01,
    MODE_T    = 2'b10,
    MODE_NONE = 2'b11
  } didec_mode_e;

  // Bits [1:0] mode, [3:2] gain select, [4] clear style, [5] torque
  // limit from analog, [6] speed limit from analog.
  typedef struct packed {
    logic        spdLimAnalog;
    logic        trqLimAnalog;
    logic        pulseClearLevel;
    logic [1:0]  gainSwitchSel;
    didec_mode_e mode;
  } didec_ctrl_s;

  localparam didec_ctrl_s CTRL_RST = '{1'b0, 1'b0, 1'b0, 2'h0, MODE_PT};

  typedef struct packed {
    logic speedCap;
    logic torqueCap;
    logic cmdReverse;
    logic zeroHold;
    logic pulseClear;
    logic gainBoost;
    logic alarmClear;
    logic servoOn;
  } didec_req_s;

endpackage : didec_pkg

// *** hw/didec_top.sv ***
`timescale 1ns/1ps
module didec_top
  import didec_pkg::*;
#(
  parameter int unsigned NUM_DI = 4
) (
  input  wire logic              clk,
  input  wire logic              alarm_clear_input_n,
  input  wire logic [ADDR_W-1:0] address,
  input  wire logic              read,
  input  wire logic              write,
  input  wire logic [31:0]       writedata,
  input  wire logic [3:0]        byteenable,
  output logic      [31:0]       readdata,
  output logic                   waitrequest,
  input  wire logic [NUM_DI-1:0] din,
  input  wire logic [15:0]       measSpeed,
  input  wire logic              alarmActive,
  output didec_req_s             reqQ,
  output logic                   torqueLimitAnalog,
  output logic                   speedLimitAnalog
);

  ////////////////////////////////////////////////////////////////////////////
  // Register bus slave. Every access is answered on the second cycle, so
  // the master sees waitrequest high for exactly one cycle.

  didec_ctrl_s ctrlQ;
  logic [15:0] threshQ;
  logic [31:0] funcQ;
  logic        ackQ;
  logic [31:0] beMask;
  logic        wrTake;
  logic [31:0] ctrlWord;
  logic [31:0] ctrlMerged;
  logic [31:0] threshMerged;

  assign waitrequest = (read | write) & ~ackQ;
  assign wrTake      = write & ackQ;
  assign ctrlWord    = {{(32-CTRL_W){1'b0}}, ctrlQ};

  for (genvar b = 0; b < 4; b++) begin : g_be
    assign beMask[8*b +: 8] = {8{byteenable[b]}};
  end

  always_ff @(posedge clk or negedge alarm_clear_input_n) begin
    if (!alarm_clear_input_n) begin
      ackQ <= 1'b0;
    end else begin
      ackQ <= (read | write) & ~ackQ;
    end
  end

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [31:0] m);
    merge = (old & ~m) | (wd & m);
  endfunction : merge

  assign ctrlMerged   = merge(ctrlWord, writedata, beMask);
  assign threshMerged = merge({16'h0000, threshQ}, writedata, beMask);

  always_ff @(posedge clk or negedge alarm_clear_input_n) begin
    if (!alarm_clear_input_n) begin
      ctrlQ <= CTRL_RST;
    end else if (wrTake && address == ADDR_CTRL) begin
      ctrlQ <= didec_ctrl_s'(ctrlMerged[CTRL_W-1:0]);
    end
  end

  always_ff @(posedge clk or negedge alarm_clear_input_n) begin
    if (!alarm_clear_input_n) begin
      threshQ <= THRESH_RST;
    end else if (wrTake && address == ADDR_THRESH) begin
      threshQ <= threshMerged[15:0];
    end
  end

  // Codes for input i sit in byte i; codes not listed act as reserved.
  always_ff @(posedge clk or negedge alarm_clear_input_n) begin
    if (!alarm_clear_input_n) begin
      funcQ <= FUNC_RST;
    end else if (wrTake && address == ADDR_FUNC) begin
      funcQ <= merge(funcQ, writedata, beMask);
    end
  end

  // Read data is latched in the waiting cycle and held until the next read.
  always_ff @(posedge clk or negedge alarm_clear_input_n) begin
    if (!alarm_clear_input_n) begin
      readdata <= 32'h0000_0000;
    end else if (read && !ackQ) begin
      case (address)
        ADDR_CTRL:   readdata <= ctrlWord;
        ADDR_THRESH: readdata <= {16'h0000, threshQ};
        ADDR_FUNC:   readdata <= funcQ;
        ADDR_STATUS: begin
          readdata <= 32'h0000_0000;
          readdata[STATUS_DIN_LSB +: NUM_DI] <= din;
          readdata[7:0] <= reqQ;
        end
        default:     readdata <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input decode. Each input maps through its own slot, then all are merged.

  logic [NUM_DI-1:0] rise;
  didec_req_s        slotHits [NUM_DI];
  didec_req_s        anyHit;
  didec_req_s        reqD;

  didec_edge_detect #(
    .W (NUM_DI)
  ) u_edge (
    .clk    (clk),
    .alarm_clear_input_n (alarm_clear_input_n),
    .din    (din),
    .rise   (rise)
  );

  for (genvar i = 0; i < NUM_DI; i++) begin : g_slot
    didec_func_slot u_slot (
      .code       (funcQ[8*i +: 8]),
      .level      (din[i]),
      .rise       (rise[i]),
      .clearLevel (ctrlQ.pulseClearLevel),
      .hits       (slotHits[i])
    );
  end

  always_comb begin
    anyHit = '0;
    for (int k = 0; k < NUM_DI; k++) begin
      anyHit = anyHit | slotHits[k];
    end
  end

  // A function outside its listed modes is dropped here.
  always_comb begin
    reqD            = '0;
    reqD.servoOn    = anyHit.servoOn;
    reqD.alarmClear = anyHit.alarmClear & ~alarmActive;
    reqD.gainBoost  = anyHit.gainBoost
                      & (ctrlQ.mode == MODE_PT || ctrlQ.mode == MODE_S)
                      & (ctrlQ.gainSwitchSel == GAIN_SEL_ON);
    reqD.pulseClear = anyHit.pulseClear & (ctrlQ.mode == MODE_PT);
    reqD.zeroHold   = anyHit.zeroHold & (ctrlQ.mode == MODE_S)
                      & (measSpeed < threshQ);
    reqD.cmdReverse = anyHit.cmdReverse
                      & (ctrlQ.mode == MODE_S || ctrlQ.mode == MODE_T);
    reqD.torqueCap  = anyHit.torqueCap
                      & (ctrlQ.mode == MODE_PT || ctrlQ.mode == MODE_S);
    reqD.speedCap   = anyHit.speedCap & (ctrlQ.mode == MODE_T);
  end

  // Requests are registered so downstream sees glitch-free levels, at the
  // cost of one clock of latency from the contact.
  always_ff @(posedge clk or negedge alarm_clear_input_n) begin
    if (!alarm_clear_input_n) begin
      reqQ <= '0;
    end else begin
      reqQ <= reqD;
    end
  end

  // The limit source only matters while the matching cap is asserted.
  always_ff @(posedge clk or negedge alarm_clear_input_n) begin
    if (!alarm_clear_input_n) begin
      torqueLimitAnalog <= 1'b0;
      speedLimitAnalog  <= 1'b0;
    end else begin
      torqueLimitAnalog <= reqD.torqueCap & ctrlQ.trqLimAnalog;
      speedLimitAnalog  <= reqD.speedCap & ctrlQ.spdLimAnalog;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!alarm_clear_input_n);

  a_servo_follow: assert property (
    (din[0] && funcQ[7:0] == CODE_SERVO) |=> reqQ.servoOn)
    else $error("servo request missing while input on");

  a_servo_drop: assert property (
    (funcQ[7:0] == CODE_SERVO && funcQ[31:8] == 24'h000000 && !din[0])
    |=> !reqQ.servoOn)
    else $error("servo request with its input off");

  a_alarm_gone: assert property (
    reqQ.alarmClear |-> $past(!alarmActive) && $past(|rise))
    else $error("alarm clear without edge or with alarm present");

  a_gain_mode: assert property (
    reqQ.gainBoost |-> $past(ctrlQ.gainSwitchSel) == GAIN_SEL_ON
                       && $past(ctrlQ.mode) inside {MODE_PT, MODE_S})
    else $error("gain boost in wrong mode or select");

  a_clear_edge: assert property (
    (!ctrlQ.pulseClearLevel && din[0] && funcQ[7:0] == CODE_PCLEAR
     && funcQ[31:8] == 24'h000000 && ctrlQ.mode == MODE_PT)
    ##1 (din[0] && !ctrlQ.pulseClearLevel) |=> !reqQ.pulseClear)
    else $error("edge-style clear held longer than one cycle");

  a_zero_thresh: assert property (
    reqQ.zeroHold |-> $past(measSpeed) < $past(threshQ)
                      && $past(ctrlQ.mode) == MODE_S)
    else $error("zero hold above threshold or outside speed mode");

  a_reverse_mode: assert property (
    reqQ.cmdReverse |-> $past(ctrlQ.mode) inside {MODE_S, MODE_T})
    else $error("command reverse outside speed or torque mode");

  a_torque_mode: assert property (
    reqQ.torqueCap |-> $past(ctrlQ.mode) inside {MODE_PT, MODE_S})
    else $error("torque cap outside position or speed mode");

  a_speed_mode: assert property (
    reqQ.speedCap |-> $past(ctrlQ.mode) == MODE_T)
    else $error("speed cap outside torque mode");

  a_reserved_quiet: assert property (
    (funcQ[7:0] == CODE_RESERVED && funcQ[31:8] == 24'h000000) |=> reqQ == '0)
    else $error("reserved code produced a request");

  a_edge_single: assert property (
    rise[0] |=> !rise[0])
    else $error("edge pulse longer than one cycle");

  a_bus_answer: assert property (
    ((read || write) && waitrequest) |=> !waitrequest)
    else $error("bus access not answered on second cycle");

  a_alarm_edge: assert property (
    (rise[0] && funcQ[7:0] == CODE_ALARM && !alarmActive)
    |=> reqQ.alarmClear)
    else $error("alarm clear missing after rising edge");

  a_gain_level: assert property (
    (din[0] && funcQ[7:0] == CODE_GAIN && ctrlQ.mode == MODE_S
     && ctrlQ.gainSwitchSel == GAIN_SEL_ON) |=> reqQ.gainBoost)
    else $error("gain boost missing in speed mode");

  a_clear_level: assert property (
    (ctrlQ.pulseClearLevel && ctrlQ.mode == MODE_PT && din[0]
     && funcQ[7:0] == CODE_PCLEAR) |=> reqQ.pulseClear)
    else $error("level-style clear missing while input on");

  a_zero_hold: assert property (
    (din[0] && funcQ[7:0] == CODE_ZHOLD && ctrlQ.mode == MODE_S
     && measSpeed < threshQ) |=> reqQ.zeroHold)
    else $error("zero hold missing below threshold");

  a_torque_src: assert property (
    torqueLimitAnalog |-> reqQ.torqueCap && $past(ctrlQ.trqLimAnalog))
    else $error("analog torque source without torque cap");

  a_speed_src: assert property (
    speedLimitAnalog |-> reqQ.speedCap && $past(ctrlQ.spdLimAnalog))
    else $error("analog speed source without speed cap");

  a_ctrl_write: assert property (
    (wrTake && address == ADDR_CTRL && byteenable[0])
    |=> ctrlQ == $past(writedata[CTRL_W-1:0]))
    else $error("control write not stored");

  a_thresh_write: assert property (
    (wrTake && address == ADDR_THRESH && byteenable[1:0] == 2'h3)
    |=> threshQ == $past(writedata[15:0]))
    else $error("threshold write not stored");

  a_func_write: assert property (
    (wrTake && address == ADDR_FUNC && byteenable == 4'hF)
    |=> funcQ == $past(writedata))
    else $error("function write not stored");

  a_status_ro: assert property (
    (wrTake && address == ADDR_STATUS)
    |=> $stable(ctrlQ) && $stable(threshQ) && $stable(funcQ))
    else $error("status write changed a register");

  a_read_hold: assert property (
    !read |=> $stable(readdata))
    else $error("read data changed without a read");

  a_wait_first: assert property (
    $rose(read || write) |-> waitrequest)
    else $error("new access not held off for one cycle");

  c_servo_on:  cover property (!reqQ.servoOn ##1 reqQ.servoOn);
  c_alarm_clr: cover property (reqQ.alarmClear);
  c_speed_cap: cover property (reqQ.speedCap && speedLimitAnalog);
  c_ctrl_wr:   cover property (wrTake && address == ADDR_CTRL);
  c_zero_hold: cover property (reqQ.zeroHold);

endmodule : didec_top

// *** verif/didec_ctrl_model.sv ***
`timescale 1ns/1ps
module didec_ctrl_model (
  input  wire logic       clk,
  output logic      [3:0] contacts
);
  ////////////////////////////////////////////////////////////////////////////
  // The controller moves its contacts only just after an edge, so the
  // decoder never sees a level change inside its own sampling step.
  initial contacts = 4'h0;

  task automatic drive(input logic [3:0] v);
    @(posedge clk);
    contacts <= v;
  endtask : drive
endmodule : didec_ctrl_model

// *** verif/didec_top_tb.sv ***
`timescale 1ns/1ps
module didec_top_tb;
  import didec_pkg::*;
  logic             clk;
  logic             rstN;
  logic [3:0]       address;
  logic             read;
  logic             write;
  logic [31:0]      writedata;
  logic [3:0]       byteenable;
  logic [31:0]      readdata;
  logic             waitrequest;
  logic [3:0]       din;
  logic [15:0]      measSpeed;
  logic             alarmActive;
  didec_req_s       reqQ;
  logic             torqueLimitAnalog;
  logic             speedLimitAnalog;
  int               errCount = 0;
  int               checked = 0;

  // Each entry: control byte, function code, speed, expected requests.
  localparam logic [39:0] CS [21] = '{
    {8'h00, CODE_SERVO, 16'h0000, 8'h01}, {8'h02, CODE_SERVO, 16'h0000, 8'h01},
    {8'h04, CODE_GAIN, 16'h0000, 8'h04}, {8'h05, CODE_GAIN, 16'h0000, 8'h04},
    {8'h06, CODE_GAIN, 16'h0000, 8'h00}, {8'h01, CODE_GAIN, 16'h0000, 8'h00},
    {8'h10, CODE_PCLEAR, 16'h0000, 8'h08}, {8'h11, CODE_PCLEAR, 16'h0000, 8'h00},
    {8'h01, CODE_ZHOLD, 16'h0009, 8'h10}, {8'h01, CODE_ZHOLD, 16'h000A, 8'h00},
    {8'h00, CODE_ZHOLD, 16'h0000, 8'h00}, {8'h01, CODE_REVERSE, 16'h0000, 8'h20},
    {8'h02, CODE_REVERSE, 16'h0000, 8'h20}, {8'h00, CODE_REVERSE, 16'h0000, 8'h00},
    {8'h20, CODE_TRQCAP, 16'h0000, 8'h40}, {8'h21, CODE_TRQCAP, 16'h0000, 8'h40},
    {8'h02, CODE_TRQCAP, 16'h0000, 8'h00}, {8'h42, CODE_SPDCAP, 16'h0000, 8'h80},
    {8'h41, CODE_SPDCAP, 16'h0000, 8'h00}, {8'h00, CODE_RESERVED, 16'h0000, 8'h00},
    {8'h00, 8'h08, 16'h0000, 8'h00}};

  didec_top dut (.clk(clk), .alarm_clear_input_n(rstN), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest), .din(din),
    .measSpeed(measSpeed), .alarmActive(alarmActive), .reqQ(reqQ),
    .torqueLimitAnalog(torqueLimitAnalog), .speedLimitAnalog(speedLimitAnalog));
  didec_ctrl_model ctl (.clk(clk), .contacts(din));

  always #12.5 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errCount++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // Requests start one edge after the last release, never in the same step.
  task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    address   <= a;
    writedata <= d;
    write     <= 1'b1;
    do @(posedge clk); while (waitrequest !== 1'b0);
    write <= 1'b0;
  endtask : bus_wr

  task automatic bus_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    address <= a;
    read    <= 1'b1;
    do @(posedge clk); while (waitrequest !== 1'b0);
    d = readdata;
    read <= 1'b0;
  endtask : bus_rd

  task automatic setup(input logic [7:0] ctrl, input logic [7:0] code);
    ctl.drive(4'h0);
    bus_wr(ADDR_CTRL, {24'h0, ctrl});
    bus_wr(ADDR_FUNC, {24'h0, code});
  endtask : setup

  // Counts cycles with the request set over four cycles after a rise.
  task automatic pulse(input logic [7:0] ctrl, input logic [7:0] code,
                       input logic alm, input logic [7:0] mask, output int n);
    setup(ctrl, code);
    alarmActive <= alm;
    repeat (2) @(posedge clk);
    ctl.drive(4'h1);
    n = 0;
    repeat (4) begin @(posedge clk); #1; if ((reqQ & mask) !== 8'h00) n++; end
    alarmActive <= 1'b0;
  endtask : pulse

  task automatic summarize();
    $display("counts checked=%0d mismatches=%0d", checked, errCount);
    if (errCount == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : summarize

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] rd;
    int          n;
    clk = 1'b0; rstN = 1'b0; address = 4'h0; read = 1'b0; write = 1'b0;
    writedata = 32'h0; byteenable = 4'hF; measSpeed = 16'h0;
    alarmActive = 1'b0;
    repeat (4) @(posedge clk);
    rstN <= 1'b1;
    bus_rd(ADDR_CTRL, rd); chk(rd, 32'h0);
    bus_rd(ADDR_THRESH, rd); chk(rd, {16'h0, THRESH_RST});
    bus_rd(ADDR_FUNC, rd); chk(rd, FUNC_RST);
    bus_rd(4'h1, rd); chk(rd, 32'h0);
    bus_wr(ADDR_STATUS, 32'hFFFFFFFF);
    bus_rd(ADDR_STATUS, rd); chk(rd, 32'h0);
    bus_wr(ADDR_THRESH, 32'h5A5A000A);
    bus_rd(ADDR_THRESH, rd); chk(rd, 32'hA);
    $display("test registers done");
    for (int i = 0; i < 21; i++) begin
      setup(CS[i][39:32], CS[i][31:24]);
      measSpeed <= CS[i][23:8];
      ctl.drive(4'h1);
      repeat (3) @(posedge clk);
      #1;
      chk({24'h0, reqQ}, {24'h0, CS[i][7:0]});
      chk({30'h0, torqueLimitAnalog, speedLimitAnalog},
          {30'h0, CS[i][6] & CS[i][37], CS[i][7] & CS[i][38]});
    end
    measSpeed <= 16'h0;
    $display("test level functions done");
    pulse(8'h00, CODE_ALARM, 1'b0, 8'h02, n); chk(n, 32'h1);
    pulse(8'h02, CODE_ALARM, 1'b1, 8'h02, n); chk(n, 32'h0);
    pulse(8'h00, CODE_PCLEAR, 1'b0, 8'h08, n); chk(n, 32'h1);
    pulse(8'h10, CODE_PCLEAR, 1'b0, 8'h08, n); chk(n, 32'h4);
    $display("test edge functions done");
    summarize();
  end

  // Whole run needs about 320 cycles; this limit only catches a hang.
  initial begin
    repeat (5000) @(posedge clk);
    errCount++;
    summarize();
  end
endmodule : didec_top_tb
